// [design/drp_regs.svh]
// Page layout, field encodings and timing counts for the disconnect/reconnect policy block.
// Assumes byte-wide access to the parameter page, with the most significant byte at the lower offset.
`ifndef DRP_REGS_SVH
`define DRP_REGS_SVH

// Byte offsets within the parameter page
`define DRP_OFF_PAGE_HEADER 4'h0
`define DRP_OFF_PAGE_LENGTH 4'h1
`define DRP_OFF_FULL_RATIO 4'h2
`define DRP_OFF_EMPTY_RATIO 4'h3
`define DRP_OFF_INACT_MSB 4'h4
`define DRP_OFF_INACT_LSB 4'h5
`define DRP_OFF_DISC_MSB 4'h6
`define DRP_OFF_DISC_LSB 4'h7
`define DRP_OFF_CONN_MSB 4'h8
`define DRP_OFF_CONN_LSB 4'h9
`define DRP_OFF_BURST_MSB 4'ha
`define DRP_OFF_BURST_LSB 4'hb
`define DRP_OFF_XFER_CTL 4'hc

// Fixed header contents
`define DRP_PAGE_CODE 6'h02
`define DRP_PAGE_LEN 8'h0e
`define DRP_SAVABLE_BIT 7

// Transfer-disconnect control encodings
`define DRP_XDC_OFF 2'b00
`define DRP_XDC_DATA 2'b01
`define DRP_XDC_RSVD 2'b10
`define DRP_XDC_CMD 2'b11

// Ratio denominator as a shift, and burst unit in bytes
`define DRP_RATIO_SHIFT 8
`define DRP_BURST_BYTES 512

// Sense answer for a conflicting page
`define DRP_SENSE_ILLEGAL_REQ 4'h5
`define DRP_ASC_BAD_PARAM 8'h26

// Timer unit and clock period
`define DRP_UNIT_NS 100000
`define DRP_CLK_NS 50
`define DRP_UNIT_CYCLES (`DRP_UNIT_NS / `DRP_CLK_NS)

`endif

// [design/drp_pkg.sv]
// Types shared by the disconnect/reconnect policy block.
// Assumes drp_regs.svh supplies the numeric constants.
package drp_pkg;

  // Bus events reported by the target's phase sequencer, same clock
  typedef struct packed {
    logic connect;
    logic release_bus;
    logic handshake;
    logic data_start;
    logic data_done;
    logic cmd_done;
    logic byte_moved;
  } drp_bus_ev_t;

  // Sense answer for a refused page
  typedef struct packed {
    logic [3:0] key;
    logic [7:0] asc;
  } drp_sense_t;

  typedef enum logic [1:0] {
    DRP_IDLE,
    DRP_CONNECTED,
    DRP_RELEASED
  } drp_state_t;

endpackage

// [design/drp_tick.sv]
// Unit tick generator: one-cycle pulse every UNIT cycles, restartable.
// Assumes a single clock; restart comes from logic on the same clock.
`timescale 1ns/1ps
module drp_tick #(
  parameter int unsigned UNIT = 2000
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic restart,
  output logic tick
);
  import drp_pkg::*;

  logic [$clog2(UNIT+1)-1:0] cnt;
  wire logic at_end = (cnt == $bits(cnt)'(UNIT - 1));

  // Divider, restarted at each connection or release
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      cnt <= (restart || at_end) ? '0 : cnt + 1'b1;
      tick <= at_end && !restart;
    end
  end
endmodule

// [design/drp_policy.sv]
// Disconnect/reconnect policy: parameter page storage and the release/reselect decisions.
// Assumes the phase sequencer reports bus events as same-clock pulses and owns the pins.
//
// Summary of operation
// [R1] On reads, reselect only once buffer fill reaches full ratio share, rounded down.
// [R2] On writes, reselect only once buffer emptiness reaches empty ratio share.
// [R3] Ratios are n/256 and advisory; zero leaves reselection to the disconnect wait.
// [R4] Count 100 us of BSY without handshake; past limit, disconnect if permitted.
// [R5] Inactivity limit zero disables the inactivity timeout entirely.
// [R6] After release, wait at least disconnect limit units before reselecting; zero none.
// [R7] Disconnect before connect limit units on the bus when permitted; zero means none.
// [R8] Time limits are honoured at whole 100 us tick granularity.
// [R9] With privilege, disconnect before exceeding burst limit of 512 byte units; zero none.
// [R10] Control 00b does not restrict disconnects; 10b is reserved, treated as unrestricted.
// [R11] Control 01b forbids disconnect from data start until all data has moved.
// [R12] Control 11b forbids disconnect from data start until command completes.
// [R13] Refuse page with both control and burst non-zero: illegal request sense.
// [R14] Initiator writes consistent pages, multi-byte fields most significant byte first.
// [R15] Timers restart on connect or release, clear on reset, compare full 16 bits.
`timescale 1ns/1ps
`include "drp_regs.svh"
module drp_policy
  import drp_pkg::*;
#(
  parameter int unsigned NUM_BUFFERS = 10,
  parameter int unsigned UNIT_CYCLES = `DRP_UNIT_CYCLES,
  parameter bit SAVABLE = 1'b0
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic page_wr,
  input wire logic [3:0] page_addr,
  input wire logic [7:0] page_wdata,
  input wire logic page_commit,
  output logic [7:0] page_rdata,
  input wire drp_bus_ev_t bus_ev,
  input wire logic disc_privilege,
  input wire logic read_op,
  input wire logic [7:0] buffers_full,
  output logic disconnect_req,
  output logic reselect_ok,
  output logic check_condition,
  output drp_sense_t sense
);

  // Staged page bytes written by the initiator
  logic [7:0] stage_full, stage_empty;
  logic [15:0] stage_inact, stage_disc, stage_conn, stage_burst;
  logic [1:0] stage_xctl;
  // Active page bytes used by the policy
  logic [7:0] buffer_full_ratio, buffer_empty_ratio;
  logic [15:0] bus_inactivity_limit, disconnect_time_limit, connect_time_limit, maximum_burst_size;
  logic [1:0] transfer_disconnect_ctl;

  drp_state_t state, next_state;
  logic [15:0] inact_cnt, conn_cnt, disc_cnt, burst_cnt;
  logic [8:0] byte_cnt;
  logic in_data, data_started, tick;

  // Write decode, most significant byte at the lower offset
  wire logic wr_full = page_wr && page_addr == `DRP_OFF_FULL_RATIO;
  wire logic wr_empty = page_wr && page_addr == `DRP_OFF_EMPTY_RATIO;
  wire logic wr_inact_h = page_wr && page_addr == `DRP_OFF_INACT_MSB;
  wire logic wr_inact_l = page_wr && page_addr == `DRP_OFF_INACT_LSB;
  wire logic wr_disc_h = page_wr && page_addr == `DRP_OFF_DISC_MSB;
  wire logic wr_disc_l = page_wr && page_addr == `DRP_OFF_DISC_LSB;
  wire logic wr_conn_h = page_wr && page_addr == `DRP_OFF_CONN_MSB;
  wire logic wr_conn_l = page_wr && page_addr == `DRP_OFF_CONN_LSB;
  wire logic wr_burst_h = page_wr && page_addr == `DRP_OFF_BURST_MSB;
  wire logic wr_burst_l = page_wr && page_addr == `DRP_OFF_BURST_LSB;
  wire logic wr_xctl = page_wr && page_addr == `DRP_OFF_XFER_CTL;

  // [R13] conflicting page check
  wire logic page_conflict = (stage_xctl != `DRP_XDC_OFF) && (stage_burst != 16'h0000);
  wire logic page_accept = page_commit && !page_conflict;
  wire logic page_refuse = page_commit && page_conflict;

  // Staged byte writes
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stage_full <= 8'h00;
      stage_empty <= 8'h00;
      stage_inact <= 16'h0000;
      stage_disc <= 16'h0000;
      stage_conn <= 16'h0000;
      stage_burst <= 16'h0000;
      stage_xctl <= 2'b00;
    end else begin
      if (wr_full) stage_full <= page_wdata;
      if (wr_empty) stage_empty <= page_wdata;
      if (wr_inact_h) stage_inact[15:8] <= page_wdata;
      if (wr_inact_l) stage_inact[7:0] <= page_wdata;
      if (wr_disc_h) stage_disc[15:8] <= page_wdata;
      if (wr_disc_l) stage_disc[7:0] <= page_wdata;
      if (wr_conn_h) stage_conn[15:8] <= page_wdata;
      if (wr_conn_l) stage_conn[7:0] <= page_wdata;
      if (wr_burst_h) stage_burst[15:8] <= page_wdata;
      if (wr_burst_l) stage_burst[7:0] <= page_wdata;
      if (wr_xctl) stage_xctl <= page_wdata[1:0];
    end
  end

  // Commit copies a consistent page into the active set
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      buffer_full_ratio <= 8'h00;
      buffer_empty_ratio <= 8'h00;
      bus_inactivity_limit <= 16'h0000;
      disconnect_time_limit <= 16'h0000;
      connect_time_limit <= 16'h0000;
      maximum_burst_size <= 16'h0000;
      transfer_disconnect_ctl <= 2'b00;
    end else if (page_accept) begin
      buffer_full_ratio <= stage_full;
      buffer_empty_ratio <= stage_empty;
      bus_inactivity_limit <= stage_inact;
      disconnect_time_limit <= stage_disc;
      connect_time_limit <= stage_conn;
      maximum_burst_size <= stage_burst;
      transfer_disconnect_ctl <= stage_xctl;
    end
  end

  // [R13] refusal answer holds until the next commit
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      check_condition <= 1'b0;
      sense <= '0;
    end else if (page_commit) begin
      check_condition <= page_conflict;
      sense.key <= page_refuse ? `DRP_SENSE_ILLEGAL_REQ : 4'h0;
      sense.asc <= page_refuse ? `DRP_ASC_BAD_PARAM : 8'h00;
    end
  end

  // Read multiplexer over the active page; reserved bytes read zero
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    case (page_addr)
      `DRP_OFF_PAGE_HEADER: next_rdata = {SAVABLE, 1'b0, `DRP_PAGE_CODE};
      `DRP_OFF_PAGE_LENGTH: next_rdata = `DRP_PAGE_LEN;
      `DRP_OFF_FULL_RATIO: next_rdata = buffer_full_ratio;
      `DRP_OFF_EMPTY_RATIO: next_rdata = buffer_empty_ratio;
      `DRP_OFF_INACT_MSB: next_rdata = bus_inactivity_limit[15:8];
      `DRP_OFF_INACT_LSB: next_rdata = bus_inactivity_limit[7:0];
      `DRP_OFF_DISC_MSB: next_rdata = disconnect_time_limit[15:8];
      `DRP_OFF_DISC_LSB: next_rdata = disconnect_time_limit[7:0];
      `DRP_OFF_CONN_MSB: next_rdata = connect_time_limit[15:8];
      `DRP_OFF_CONN_LSB: next_rdata = connect_time_limit[7:0];
      `DRP_OFF_BURST_MSB: next_rdata = maximum_burst_size[15:8];
      `DRP_OFF_BURST_LSB: next_rdata = maximum_burst_size[7:0];
      `DRP_OFF_XFER_CTL: next_rdata = {6'h00, transfer_disconnect_ctl};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) page_rdata <= 8'h00;
    else page_rdata <= next_rdata;
  end

  // Connection state from the sequencer's events
  always_comb begin
    next_state = state;
    case (state)
      DRP_IDLE: if (bus_ev.connect) next_state = DRP_CONNECTED;
      DRP_CONNECTED: if (bus_ev.release_bus) next_state = DRP_RELEASED;
      DRP_RELEASED: if (bus_ev.connect) next_state = DRP_CONNECTED;
      default: next_state = DRP_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) state <= DRP_IDLE;
    else state <= next_state;
  end

  // [R8] time measured in whole 100 us ticks
  drp_tick #(
    .UNIT(UNIT_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .reset_n(reset_n),
    .restart(bus_ev.connect || bus_ev.release_bus),
    .tick(tick)
  );

  wire logic connected = (state == DRP_CONNECTED);
  wire logic released = (state == DRP_RELEASED);
  wire logic restart = bus_ev.connect || bus_ev.release_bus;

  // [R15] timers restart on connect or release and saturate
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      inact_cnt <= 16'h0000;
      conn_cnt <= 16'h0000;
      disc_cnt <= 16'h0000;
    end else if (restart) begin
      inact_cnt <= 16'h0000;
      conn_cnt <= 16'h0000;
      disc_cnt <= 16'h0000;
    end else begin
      // [R4] inactivity clears on every handshake
      if (bus_ev.handshake) inact_cnt <= 16'h0000;
      else if (connected && tick && inact_cnt != 16'hffff) inact_cnt <= inact_cnt + 16'h0001;
      if (connected && tick && conn_cnt != 16'hffff) conn_cnt <= conn_cnt + 16'h0001;
      if (released && tick && disc_cnt != 16'hffff) disc_cnt <= disc_cnt + 16'h0001;
    end
  end

  // [R9] burst counted in 512 byte units per data phase
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      byte_cnt <= 9'h000;
      burst_cnt <= 16'h0000;
    end else if (restart || bus_ev.data_start) begin
      byte_cnt <= 9'h000;
      burst_cnt <= 16'h0000;
    end else if (bus_ev.byte_moved) begin
      byte_cnt <= byte_cnt + 9'h001;
      if (byte_cnt == 9'(`DRP_BURST_BYTES - 1) && burst_cnt != 16'hffff) burst_cnt <= burst_cnt + 16'h0001;
    end
  end

  // Data and command progress for the transfer-disconnect lock
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      in_data <= 1'b0;
      data_started <= 1'b0;
    end else begin
      if (bus_ev.data_start) in_data <= 1'b1;
      else if (bus_ev.data_done) in_data <= 1'b0;
      if (bus_ev.data_start) data_started <= 1'b1;
      else if (bus_ev.cmd_done) data_started <= 1'b0;
    end
  end

  // [R10] 00b and reserved 10b leave disconnects unrestricted
  // [R11] 01b locks from data start until data done
  // [R12] 11b locks from data start until command done
  wire logic xfer_lock = (transfer_disconnect_ctl == `DRP_XDC_DATA && in_data) ||
                         (transfer_disconnect_ctl == `DRP_XDC_CMD && data_started);

  // [R5] zero limit disables the inactivity timeout
  // [R4] inactivity past the limit
  wire logic inact_exp = (bus_inactivity_limit != 16'h0000) && (inact_cnt >= bus_inactivity_limit);
  // [R7] connect time reached
  wire logic conn_exp = (connect_time_limit != 16'h0000) && (conn_cnt >= connect_time_limit);
  // [R9] burst limit reached
  wire logic burst_exp = (maximum_burst_size != 16'h0000) && (burst_cnt >= maximum_burst_size);

  // Disconnect request while connected, privileged and not locked
  wire logic next_disc = connected && disc_privilege && !xfer_lock && (inact_exp || conn_exp || burst_exp);

  // [R3] ratio scaled by buffer count over 256, rounded down
  // [R1] read reselect threshold
  wire logic [15:0] full_need = 16'((32'(buffer_full_ratio) * NUM_BUFFERS) >> `DRP_RATIO_SHIFT);
  // [R2] write reselect threshold
  wire logic [15:0] empty_need = 16'((32'(buffer_empty_ratio) * NUM_BUFFERS) >> `DRP_RATIO_SHIFT);
  wire logic [15:0] free_bufs = 16'(NUM_BUFFERS) - 16'(buffers_full);
  wire logic buf_ok = read_op ? (16'(buffers_full) >= full_need) : (free_bufs >= empty_need);

  // [R6] minimum wait after release
  wire logic disc_wait_done = (disc_cnt >= disconnect_time_limit);
  wire logic next_resel = released && !restart && disc_wait_done && buf_ok;

  // Registered policy outputs
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      disconnect_req <= 1'b0;
      reselect_ok <= 1'b0;
    end else begin
      disconnect_req <= next_disc && !restart;
      reselect_ok <= next_resel;
    end
  end

endmodule

// [tb/drp_seq_model.sv]
// Model of the phase sequencer that reports bus events to the policy block.
// Assumes the bench calls ev() once per event, connect before release.
`timescale 1ns/1ps
module drp_seq_model
  import drp_pkg::*;
(
  input wire logic mclk,
  output drp_bus_ev_t bus_ev
);
  initial bus_ev = '0;

  // One-cycle event pulse launched just after a rising edge
  task automatic ev(input logic [6:0] m);
    @(posedge mclk);
    bus_ev <= drp_bus_ev_t'(m);
    @(posedge mclk);
    bus_ev <= '0;
    // Step off the edge so callers see settled outputs
    #1;
  endtask
endmodule

// [tb/drp_policy_props.sv]
// Checker for the disconnect/reconnect policy block.
// Assumes it is bound onto drp_policy and sees only its ports.
`timescale 1ns/1ps
`include "drp_regs.svh"
module drp_policy_props
  import drp_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic page_wr,
  input wire logic [3:0] page_addr,
  input wire logic [7:0] page_wdata,
  input wire logic page_commit,
  input wire logic [7:0] page_rdata,
  input wire drp_bus_ev_t bus_ev,
  input wire logic disc_privilege,
  input wire logic disconnect_req,
  input wire logic reselect_ok,
  input wire logic check_condition,
  input wire drp_sense_t sense
);
  logic conn, rel, lock;
  logic [1:0] ctl_s, ctl_a;
  logic [15:0] bur_s;
  wire bad_s = (ctl_s != 2'b00) && (bur_s != 16'h0000);
  wire unlock = bus_ev.connect | bus_ev.release_bus | (bus_ev.data_done & ~ctl_a[1]) | bus_ev.cmd_done;

  // Shadow of staged page fields, connection state and transfer lock
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      {conn, rel, lock} <= 3'b000;
      {ctl_s, ctl_a} <= 4'h0;
      bur_s <= 16'h0000;
    end else begin
      if (page_wr && page_addr == `DRP_OFF_XFER_CTL) ctl_s <= page_wdata[1:0];
      if (page_wr && page_addr == `DRP_OFF_BURST_MSB) bur_s[15:8] <= page_wdata;
      if (page_wr && page_addr == `DRP_OFF_BURST_LSB) bur_s[7:0] <= page_wdata;
      if (page_commit && !bad_s) ctl_a <= ctl_s;
      conn <= bus_ev.connect | (conn & ~bus_ev.release_bus);
      rel <= bus_ev.release_bus | (rel & ~bus_ev.connect);
      lock <= (bus_ev.data_start & ctl_a[0]) | (lock & ~unlock);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_disc_needs_priv: assert property (disconnect_req |-> $past(disc_privilege))
    else $error("disconnect asked without privilege");
  a_disc_when_conn: assert property (disconnect_req |-> conn)
    else $error("disconnect asked while not connected");
  a_connect_clears: assert property (bus_ev.connect |=> !disconnect_req && !reselect_ok)
    else $error("outputs not cleared after connect");
  a_release_clears: assert property (bus_ev.release_bus |=> !disconnect_req)
    else $error("disconnect not cleared after release");
  a_lock_holds: assert property (lock |=> !disconnect_req)
    else $error("disconnect asked during locked transfer");
  a_commit_refused: assert property (page_commit && bad_s |=> check_condition && sense == {4'h5, 8'h26})
    else $error("conflicting page not refused");
  a_commit_taken: assert property (page_commit && !bad_s |=> !check_condition && sense == 12'h000)
    else $error("consistent page refused");
  a_status_stands: assert property (!page_commit |=> $stable(check_condition) && $stable(sense))
    else $error("status changed without commit");
  a_resel_released: assert property (reselect_ok |-> rel && !conn)
    else $error("reselect allowed while not released");
endmodule

bind drp_policy drp_policy_props drp_policy_props_i (.mclk(mclk), .reset_n(reset_n), .page_wr(page_wr),
  .page_addr(page_addr), .page_wdata(page_wdata), .page_commit(page_commit), .page_rdata(page_rdata),
  .bus_ev(bus_ev), .disc_privilege(disc_privilege), .disconnect_req(disconnect_req),
  .reselect_ok(reselect_ok), .check_condition(check_condition), .sense(sense));

// [tb/testbench.sv]
// Self-checking bench for the disconnect/reconnect policy block.
// Assumes the timer unit is shortened to 20 cycles and ten buffers.
`timescale 1ns/1ps
module testbench
  import drp_pkg::*;
;
  localparam logic [6:0] EC = 7'h40, ER = 7'h20, EH = 7'h10, ES = 7'h08, ED = 7'h04, EM = 7'h02, EB = 7'h01;
  logic mclk = 1'b0, reset_n = 1'b0, page_wr = 1'b0, page_commit = 1'b0, disc_privilege = 1'b0, read_op = 1'b0;
  logic [3:0] page_addr = 4'h0;
  logic [7:0] page_wdata = 8'h00, buffers_full = 8'h00, page_rdata;
  logic disconnect_req, reselect_ok, check_condition;
  drp_sense_t sense;
  drp_bus_ev_t bus_ev;
  int miscompares = 0, n_compared = 0, cycles = 0;

  always #25 mclk = ~mclk;

  drp_seq_model m (.mclk(mclk), .bus_ev(bus_ev));
  drp_policy #(.UNIT_CYCLES(20)) drp_policy_i (.mclk(mclk), .reset_n(reset_n), .page_wr(page_wr),
    .page_addr(page_addr), .page_wdata(page_wdata), .page_commit(page_commit), .page_rdata(page_rdata),
    .bus_ev(bus_ev), .disc_privilege(disc_privilege), .read_op(read_op), .buffers_full(buffers_full),
    .disconnect_req(disconnect_req), .reselect_ok(reselect_ok), .check_condition(check_condition), .sense(sense));

  task automatic stop_test();
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    page_wr <= 1'b1;
    page_addr <= a;
    page_wdata <= d;
    @(posedge mclk);
    page_wr <= 1'b0;
  endtask
  // Multi-byte field, most significant byte first
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 4'h1, v[7:0]);
  endtask
  task automatic commit();
    @(posedge mclk);
    page_commit <= 1'b1;
    @(posedge mclk);
    page_commit <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    page_addr <= a;
    @(posedge mclk);
    #1;
    chk({8'h00, page_rdata}, {8'h00, exp});
  endtask
  task automatic wait_out(input bit sel, input int n);
    for (int i = 0; i < n; i++) begin
      if ((sel ? reselect_ok : disconnect_req) === 1'b1) break;
      cyc(1);
    end
  endtask

  // Cycle ceiling against a hang
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    // Read-only and reserved bytes ignore writes
    wr(4'h0, 8'hff);
    wr(4'hd, 8'hff);
    commit();
    rd(4'h0, 8'h02);
    rd(4'h1, 8'h0e);
    rd(4'hd, 8'h00);
    rd(4'h8, 8'h00);
    $display("test page reset done");
    // Connect limit of three units
    wr16(4'h8, 16'h0003);
    wr16(4'h6, 16'h0002);
    commit();
    chk(check_condition, 1'b0);
    rd(4'h9, 8'h03);
    disc_privilege <= 1'b1;
    m.ev(EC);
    cyc(50);
    chk(disconnect_req, 1'b0);
    wait_out(1'b0, 30);
    chk(disconnect_req, 1'b1);
    // Disconnect wait of two units
    m.ev(ER);
    cyc(30);
    chk(reselect_ok, 1'b0);
    wait_out(1'b1, 30);
    chk(reselect_ok, 1'b1);
    $display("test time limits done");
    // Ratio 3fh over ten buffers needs two
    wr(4'h2, 8'h3f);
    wr(4'h3, 8'h3f);
    wr16(4'h6, 16'h0000);
    commit();
    @(posedge mclk);
    read_op <= 1'b1;
    buffers_full <= 8'h01;
    m.ev(EC);
    m.ev(ER);
    cyc(10);
    chk(reselect_ok, 1'b0);
    buffers_full <= 8'h02;
    wait_out(1'b1, 10);
    chk(reselect_ok, 1'b1);
    @(posedge mclk);
    read_op <= 1'b0;
    buffers_full <= 8'h09;
    cyc(5);
    chk(reselect_ok, 1'b0);
    buffers_full <= 8'h08;
    wait_out(1'b1, 10);
    chk(reselect_ok, 1'b1);
    $display("test buffer ratios done");
    // Control and burst both set is refused, page unchanged
    wr(4'hc, 8'h01);
    wr16(4'ha, 16'h0001);
    commit();
    chk(check_condition, 1'b1);
    chk(sense, 12'h526);
    rd(4'hc, 8'h00);
    $display("test conflict done");
    // Control 01b locks until data done, 11b until command done
    for (int k = 0; k < 2; k++) begin
      wr16(4'ha, 16'h0000);
      wr(4'hc, k ? 8'h03 : 8'h01);
      commit();
      m.ev(EC);
      m.ev(ES);
      if (k) m.ev(ED);
      cyc(90);
      chk(disconnect_req, 1'b0);
      m.ev(k ? EM : ED);
      wait_out(1'b0, 10);
      chk(disconnect_req, 1'b1);
      m.ev(ER);
    end
    $display("test transfer lock done");
    // Inactivity: zero disables, two units times out unless handshakes come; reserved control 10b
    wr16(4'h8, 16'h0000);
    wr(4'hc, 8'h02);
    commit();
    m.ev(EC);
    cyc(100);
    chk(disconnect_req, 1'b0);
    wr16(4'h4, 16'h0002);
    commit();
    m.ev(ER);
    m.ev(EC);
    // Handshakes closer than one unit, so tick phase cannot reach the limit
    repeat (4) begin
      cyc(15);
      m.ev(EH);
    end
    chk(disconnect_req, 1'b0);
    wait_out(1'b0, 60);
    chk(disconnect_req, 1'b1);
    @(posedge mclk);
    disc_privilege <= 1'b0;
    cyc(3);
    chk(disconnect_req, 1'b0);
    $display("test inactivity done");
    // Burst limit of one unit: 512 bytes in one data phase
    wr16(4'h4, 16'h0000);
    wr(4'hc, 8'h00);
    wr16(4'ha, 16'h0001);
    commit();
    chk(check_condition, 1'b0);
    disc_privilege <= 1'b1;
    m.ev(ER);
    m.ev(EC);
    m.ev(ES);
    repeat (511) m.ev(EB);
    chk(disconnect_req, 1'b0);
    m.ev(EB);
    wait_out(1'b0, 5);
    chk(disconnect_req, 1'b1);
    $display("test burst size done");
    stop_test();
  end
endmodule
